// *** logic/sdlm_pkg.sv ***
// Constants and types of the lock, mute and sample path control block
package sdlm_pkg;
   // ***************************************
   // Clock and sample rates
   // ***************************************
   localparam int CLK_HZ  = 100_000_000;
   localparam int FS_32K  = 32_000;
   localparam int FS_44K  = 44_100;
   localparam int FS_48K  = 48_000;
   localparam int CYC_32K = CLK_HZ / FS_32K;
   localparam int CYC_44K = CLK_HZ / FS_44K;
   localparam int CYC_48K = CLK_HZ / FS_48K;
   localparam int THR_LO  = (CYC_48K + CYC_44K) / 2;
   localparam int THR_HI  = (CYC_44K + CYC_32K) / 2;
   localparam int OS_LOG2 = 6;  // 64 times oversampling
   // ***************************************
   // Data and status layout
   // ***************************************
   localparam int SAMPLE_W   = 24;
   localparam int CS_BITS    = 40;
   localparam int CS_NONPCM  = 1;
   localparam int CS_EMPH    = 3;
   localparam int FRAME_W    = 8;
   localparam int FIFO_DEPTH = 8;
   localparam int RAMP_W     = 10;  // 32 x 32 sample steps
   localparam logic [RAMP_W-1:0] GAIN_FULL = 10'h3ff;
   localparam logic SOFT_MUTE_RST = 1'b1;
   // ***************************************
   // Enumerations
   // ***************************************
   typedef enum logic [1:0] {
      SDLM_THREE_WIRE = 2'h0,
      SDLM_IIC        = 2'h1,
      SDLM_STATIC     = 2'h3
   } sdlm_mode_e;
   typedef enum logic [1:0] {
      RMP_RUN   = 2'h0,
      RMP_FALL  = 2'h1,
      RMP_MUTED = 2'h3,
      RMP_RISE  = 2'h2
   } sdlm_ramp_e;
   typedef enum logic [1:0] {
      RATE_48K = 2'h0,
      RATE_44K = 2'h1,
      RATE_32K = 2'h2
   } sdlm_rate_e;
endpackage

// *** logic/sdlm_top.sv ***
// Sample FIFO, channel processor and lock / mute control top
`timescale 1ns/1ps

// ***************************************
// Sample FIFO
// ***************************************
module sdlm_fifo #(
   parameter int W = 48,
   parameter int D = 8
) (
   input  wire logic         clock,
   input  wire logic         arst_n,
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   localparam int AW = $clog2(D);
   logic [W-1:0]  mem_ff [D];
   logic [AW-1:0] wr_ff;
   logic [AW-1:0] rd_ff;
   logic [AW:0]   cnt_ff;
   logic          push;
   logic          pop;

   // Honest flags straight from the count
   assign in_ready  = (cnt_ff != (AW+1)'(D));
   assign out_valid = (cnt_ff != '0);
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;
   assign out_data  = mem_ff[rd_ff];

   // Storage
   always_ff @(posedge clock) begin
      if (push) begin
         mem_ff[wr_ff] <= in_data;
      end
   end

   // Pointers and fill count
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         wr_ff  <= '0;
         rd_ff  <= '0;
         cnt_ff <= '0;
      end else begin
         if (push) wr_ff <= (wr_ff == AW'(D - 1)) ? '0 : wr_ff + 1'b1;
         if (pop)  rd_ff <= (rd_ff == AW'(D - 1)) ? '0 : rd_ff + 1'b1;
         cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule // sdlm_fifo

// ***************************************
// One channel: tone, mute gain, interpolator, shaper
// ***************************************
module sdlm_chan import sdlm_pkg::*; (
   input  wire logic                clock,
   input  wire logic                arst_n,
   input  wire logic                load,
   input  wire logic                tick64,
   input  wire logic [SAMPLE_W-1:0] smp,
   input  wire logic [RAMP_W-1:0]   gain,
   input  wire logic [7:0]          vol,
   input  wire logic [3:0]          bass,
   input  wire logic [3:0]          treble,
   input  wire logic [1:0]          fmode,
   input  wire logic                deemph,
   output logic                     bit_out
);
   logic signed [31:0] v, hp, t, g, lp_ff, x_ff, iir_ff, prv_ff, fir_ff;
   logic signed [31:0] e_ff [5];
   logic signed [31:0] y, q;
   logic        [4:0]  sh;

   // Volume, bass / treble and de-emphasis at the sample rate
   always_comb begin
      v  = (32'(signed'(smp))
            * 32'(signed'({1'b0, 9'h100 - {1'b0, vol}}))) >>> 8;
      hp = v - lp_ff;
      sh = (fmode == 2'h2) ? 5'h3 : 5'h4;
      if (deemph) t = lp_ff;
      else if (fmode == 2'h0) t = v;
      else t = v + ((lp_ff * 32'(signed'({1'b0, bass}))) >>> sh)
                 + ((hp * 32'(signed'({1'b0, treble}))) >>> sh);
      // Raised cosine approximated by 3x^2 - 2x^3
      g = (32'(gain) * 32'(gain)) >>> RAMP_W;
      g = 3 * g - 2 * ((g * 32'(gain)) >>> RAMP_W);
   end

   // Sample rate state
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         lp_ff <= '0;
         x_ff  <= '0;
      end else if (load) begin
         lp_ff <= lp_ff + ((v - lp_ff) >>> 3);
         x_ff  <= (t * g) >>> RAMP_W;
      end
   end

   // Recursive stage then two tap FIR at 64 fs
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         iir_ff <= '0;
         prv_ff <= '0;
         fir_ff <= '0;
      end else if (tick64) begin
         iir_ff <= iir_ff + ((x_ff - iir_ff) >>> 4);
         prv_ff <= iir_ff;
         fir_ff <= (iir_ff + prv_ff) >>> 1;
      end
   end

   // Fifth order error feedback, NTF (1 - z^-1)^5
   always_comb begin
      y = fir_ff - (5 * e_ff[0] - 10 * e_ff[1] + 10 * e_ff[2]
                    - 5 * e_ff[3] + e_ff[4]);
      q = y[31] ? -32'sh800000 : 32'sh7fffff;
   end

   // Error history; clamped so a hot input cannot wrap the loop
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         e_ff    <= '{default: '0};
         bit_out <= 1'b0;
      end else if (tick64) begin
         e_ff[0] <= (q - y > 32'sh7fffff) ? 32'sh7fffff :
                    (q - y < -32'sh800000) ? -32'sh800000 : q - y;
         for (int i = 1; i < 5; i++) e_ff[i] <= e_ff[i-1];
         bit_out <= ~y[31];
      end
   end
endmodule // sdlm_chan

// ***************************************
// Top
// ***************************************
// How it works
// - Clock regeneration lock is shown on a readable lock indicator bit.
// - Lock pin high when decoder and clock locked and data is PCM.
// - Locked but non-PCM status drives the lock pin low.
// - A control setting may replace the default lock pin combination.
// - PCM detect pin low on non-PCM or burst preamble, else high.
// - Mute pin or soft mute bit gives a raised cosine soft mute.
// - The soft mute ramp spans 32 x 32 sample periods.
// - Serial mode starts muted; host must clear the soft mute bit.
// - In serial mode the mute pin always mutes.
// - Output hard muted until lock, whatever the mute pin or bit.
// - Lock mute bypass bit set to one disables the hard mute.
// - 24-bit samples and 40 channel status bits per channel readable.
// - Accept 32, 44.1 and 48 kHz sample rates.
// - Interpolate 1 fs to 64 fs with recursive then FIR filter.
// - Fifth order noise shaper at 64 fs gives a one bit stream.
// - Pins choose static, I2C or three wire control mode.
// - Static and serial modes exclusive; static uses serial defaults.
// - Static mode applies de-emphasis from the incoming stream.
// - Serial mode has volume, bass, treble and filter mode settings.
module sdlm_top import sdlm_pkg::*; #(
   parameter int DEPTH = FIFO_DEPTH
) (
   input  wire logic                clock,
   input  wire logic                arst_n,
   input  wire logic                pin_control_select,
   input  wire logic                serial_bus_select,
   input  wire logic                mute_pin,
   input  wire logic                soft_mute_wr,
   input  wire logic                soft_mute_wr_data,
   input  wire logic                lock_mute_bypass_bit,
   input  wire logic                lock_pin_raw_sel,
   input  wire logic                pll_locked,
   input  wire logic                decoder_locked,
   input  wire logic                burst_detect,
   input  wire logic                sub_valid,
   output logic                     sub_ready,
   input  wire logic                sub_right,
   input  wire logic [SAMPLE_W-1:0] sub_data,
   input  wire logic                sub_cs,
   input  wire logic                sub_block_start,
   input  wire logic [7:0]          vol_left,
   input  wire logic [7:0]          vol_right,
   input  wire logic [3:0]          bass_level,
   input  wire logic [3:0]          treble_level,
   input  wire logic [1:0]          filter_mode,
   output logic                     lock_indicator_bit,
   output logic                     lock_pin,
   output logic                     pcm_detect_pin,
   output logic [1:0]               ctrl_mode,
   output logic                     soft_mute_bit,
   output logic                     muted_status,
   output logic [SAMPLE_W-1:0]      left_sample,
   output logic [SAMPLE_W-1:0]      right_sample,
   output logic [CS_BITS-1:0]       cs_left,
   output logic [CS_BITS-1:0]       cs_right,
   output logic [1:0]               rate_code,
   output logic                     dac_left_bit,
   output logic                     dac_right_bit
);
   localparam int PW = 2 * SAMPLE_W;
   sdlm_mode_e          mode;
   sdlm_ramp_e          ramp_ff;
   logic                serial, locked, hard_mute, mute_req, take;
   logic [FRAME_W-1:0]  frame_ff;
   logic [11:0]         per_cnt_ff, period_ff, div_ff;
   logic [OS_LOG2-1:0]  sub64_ff;
   logic                tick64, frame_tick, f_valid, f_ready;
   logic [PW-1:0]       f_data;
   logic [SAMPLE_W-1:0] hold_ff, pl, pr;
   logic [RAMP_W-1:0]   gain_ff;
   logic                nonpcm, sm_ff;

   // Control mode from strap pins
   always_comb begin
      if (pin_control_select)     mode = SDLM_STATIC;
      else if (serial_bus_select) mode = SDLM_IIC;
      else                        mode = SDLM_THREE_WIRE;
   end
   assign ctrl_mode = mode;
   assign serial    = (mode != SDLM_STATIC);

   // Soft mute bit; starts set so serial mode comes up muted
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n)                     sm_ff <= SOFT_MUTE_RST;
      else if (serial && soft_mute_wr) sm_ff <= soft_mute_wr_data;
   end
   assign soft_mute_bit = sm_ff;

   // Lock and PCM status pins
   assign locked             = pll_locked & decoder_locked;
   assign lock_indicator_bit = pll_locked;
   assign nonpcm             = cs_left[CS_NONPCM];
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         lock_pin       <= 1'b0;
         pcm_detect_pin <= 1'b0;
      end else begin
         // Raw override only reachable from the serial side
         lock_pin <= (serial && lock_pin_raw_sel) ? locked
                   : locked & ~nonpcm;
         pcm_detect_pin <= ~nonpcm & ~burst_detect;
      end
   end

   // Hard mute until lock; static mode keeps bypass at its default
   assign hard_mute = ~locked & ~(serial & lock_mute_bypass_bit);
   assign mute_req  = mute_pin | (serial & sm_ff);
   assign muted_status = hard_mute | (ramp_ff == RMP_MUTED);

   // Subframe capture and channel status per frame
   assign take = sub_valid & sub_ready;
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         hold_ff      <= '0;
         left_sample  <= '0;
         right_sample <= '0;
         cs_left      <= '0;
         cs_right     <= '0;
         frame_ff     <= '0;
      end else if (take) begin
         if (!sub_right) begin
            hold_ff     <= sub_data;
            left_sample <= sub_data;
            if (sub_block_start) frame_ff <= '0;
            if (sub_block_start) cs_left[0] <= sub_cs;
            else if (frame_ff < FRAME_W'(CS_BITS))
               cs_left[frame_ff[5:0]] <= sub_cs;
         end else begin
            right_sample <= sub_data;
            if (frame_ff < FRAME_W'(CS_BITS))
               cs_right[frame_ff[5:0]] <= sub_cs;
            frame_ff <= frame_ff + 1'b1;
         end
      end
   end

   // Frame period measure and rate class
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         per_cnt_ff <= '0;
         period_ff  <= 12'(CYC_48K);
         rate_code  <= RATE_48K;
      end else if (take && sub_right) begin
         per_cnt_ff <= '0;
         period_ff  <= per_cnt_ff;
         if (per_cnt_ff > 12'(THR_HI))      rate_code <= RATE_32K;
         else if (per_cnt_ff > 12'(THR_LO)) rate_code <= RATE_44K;
         else                               rate_code <= RATE_48K;
      end else if (per_cnt_ff != 12'hfff) begin
         per_cnt_ff <= per_cnt_ff + 1'b1;
      end
   end

   // 64 fs tick from the measured period; frame tick every 64
   assign tick64     = (div_ff == '0);
   assign frame_tick = tick64 & (sub64_ff == '0);
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         div_ff   <= '0;
         sub64_ff <= '0;
      end else begin
         // Reload one short so pairs pop no slower than they arrive;
         // a slower pop would creep the FIFO full and stretch the period
         div_ff <= tick64 ? (period_ff >> OS_LOG2)
                            - 12'(|period_ff[11:OS_LOG2]) : div_ff - 1'b1;
         if (tick64) sub64_ff <= sub64_ff + 1'b1;
      end
   end

   // Sample pairs cross a FIFO; a full FIFO stalls the source
   sdlm_fifo #(.W(PW), .D(DEPTH)) u_fifo (
      .clock     (clock),
      .arst_n    (arst_n),
      .in_valid  (sub_valid & sub_right),
      .in_ready  (f_ready),
      .in_data   ({hold_ff, sub_data}),
      .out_valid (f_valid),
      .out_ready (frame_tick),
      .out_data  (f_data)
   );
   // Left halves always taken; right waits for room
   assign sub_ready = ~sub_right | f_ready;

   // Zero the path at once while hard muted
   assign pl = hard_mute ? '0 : f_data[PW-1:SAMPLE_W];
   assign pr = hard_mute ? '0 : f_data[SAMPLE_W-1:0];

   // Soft mute ramp, one step per sample period
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         ramp_ff <= RMP_MUTED;
         gain_ff <= '0;
      end else if (frame_tick) begin
         case (ramp_ff)
            RMP_RUN: begin
               if (mute_req) ramp_ff <= RMP_FALL;
            end
            RMP_FALL: begin
               if (!mute_req) ramp_ff <= RMP_RISE;
               else if (gain_ff == '0) ramp_ff <= RMP_MUTED;
               else gain_ff <= gain_ff - 1'b1;
            end
            RMP_MUTED: begin
               if (!mute_req) ramp_ff <= RMP_RISE;
            end
            default: begin
               if (mute_req) ramp_ff <= RMP_FALL;
               else if (gain_ff == GAIN_FULL) ramp_ff <= RMP_RUN;
               else gain_ff <= gain_ff + 1'b1;
            end
         endcase
      end
   end

   // Two identical channel paths
   sdlm_chan u_left (
      .clock   (clock),
      .arst_n  (arst_n),
      .load    (frame_tick),
      .tick64  (tick64),
      .smp     (f_valid ? pl : '0),
      .gain    (gain_ff),
      .vol     (serial ? vol_left : 8'h00),
      .bass    (serial ? bass_level : 4'h0),
      .treble  (serial ? treble_level : 4'h0),
      .fmode   (serial ? filter_mode : 2'h0),
      .deemph  (~serial & cs_left[CS_EMPH]),
      .bit_out (dac_left_bit)
   );
   sdlm_chan u_right (
      .clock   (clock),
      .arst_n  (arst_n),
      .load    (frame_tick),
      .tick64  (tick64),
      .smp     (f_valid ? pr : '0),
      .gain    (gain_ff),
      .vol     (serial ? vol_right : 8'h00),
      .bass    (serial ? bass_level : 4'h0),
      .treble  (serial ? treble_level : 4'h0),
      .fmode   (serial ? filter_mode : 2'h0),
      .deemph  (~serial & cs_right[CS_EMPH]),
      .bit_out (dac_right_bit)
   );
endmodule // sdlm_top

// *** verification/sdlm_chk_sva.sv ***
// Concurrent checks on the ports of the lock and mute control top
`timescale 1ns/1ps
module sdlm_chk import sdlm_pkg::*; (
   input wire logic                clock,
   input wire logic                arst_n,
   input wire logic                pin_control_select,
   input wire logic                serial_bus_select,
   input wire logic                soft_mute_wr,
   input wire logic                soft_mute_wr_data,
   input wire logic                lock_mute_bypass_bit,
   input wire logic                lock_pin_raw_sel,
   input wire logic                pll_locked,
   input wire logic                decoder_locked,
   input wire logic                burst_detect,
   input wire logic                sub_valid,
   input wire logic                sub_ready,
   input wire logic                sub_right,
   input wire logic [SAMPLE_W-1:0] sub_data,
   input wire logic [CS_BITS-1:0]  cs_left,
   input wire logic                lock_indicator_bit,
   input wire logic                lock_pin,
   input wire logic                pcm_detect_pin,
   input wire logic [1:0]          ctrl_mode,
   input wire logic                soft_mute_bit,
   input wire logic                muted_status,
   input wire logic [SAMPLE_W-1:0] left_sample,
   input wire logic [SAMPLE_W-1:0] right_sample
);
   // ***************************************
   // Properties
   // ***************************************
   default clocking cb @(posedge clock); endclocking
   default disable iff (!arst_n);
   // Raw lock selection only counts outside static mode
   wire raw_sel = lock_pin_raw_sel && !pin_control_select;
   wire nonpcm  = cs_left[CS_NONPCM];
   // Subframes taken on the input handshake
   sequence take_left;
      sub_valid && sub_ready && !sub_right;
   endsequence
   sequence take_right;
      sub_valid && sub_ready && sub_right;
   endsequence
   a_lock_ind_follow: assert property (
      lock_indicator_bit == pll_locked) else $error("lock bit wrong");
   a_lock_pin_high: assert property (
      pll_locked && decoder_locked && !nonpcm && !burst_detect |=> lock_pin)
      else $error("lock pin not raised");
   a_lock_pin_unlock: assert property (
      !pll_locked |=> !lock_pin) else $error("lock pin high unlocked");
   a_lock_pin_nonpcm: assert property (
      nonpcm && !raw_sel |=> !lock_pin) else $error("lock pin on non-PCM");
   a_lock_pin_raw: assert property (
      pll_locked && decoder_locked && raw_sel |=> lock_pin)
      else $error("raw lock select ignored");
   a_pcm_det_low: assert property (
      nonpcm || burst_detect |=> !pcm_detect_pin) else $error("pcm pin high");
   a_pcm_det_high: assert property (
      !nonpcm && !burst_detect |=> pcm_detect_pin) else $error("pcm pin low");
   a_mode_decode: assert property (
      ctrl_mode == (pin_control_select ? 2'h3 : {1'b0, serial_bus_select}))
      else $error("control mode decode wrong");
   a_soft_mute_wr: assert property (
      soft_mute_wr && !pin_control_select |=>
      soft_mute_bit == $past(soft_mute_wr_data)) else $error("mute write lost");
   a_static_hold: assert property (
      pin_control_select |=> $stable(soft_mute_bit))
      else $error("mute bit changed in static mode");
   a_hard_mute: assert property (
      !(pll_locked && decoder_locked) && !(lock_mute_bypass_bit &&
      !pin_control_select) |-> muted_status) else $error("not hard muted");
   a_left_capture: assert property (
      take_left |=> left_sample == $past(sub_data)) else $error("left lost");
   a_right_capture: assert property (
      take_right |=> right_sample == $past(sub_data)) else $error("right lost");
endmodule // sdlm_chk

// *** verification/sdlm_src.sv ***
// Subframe source standing in for the stream decoder
`timescale 1ns/1ps
module sdlm_src import sdlm_pkg::*; (
   input  wire logic           clock,
   input  wire logic           sub_ready,
   output logic                sub_valid,
   output logic                sub_right,
   output logic [SAMPLE_W-1:0] sub_data,
   output logic                sub_cs,
   output logic                sub_block_start
);
   // ***************************************
   // Source
   // ***************************************
   // Idle lines at time zero
   initial begin
      sub_valid = 1'b0;
      sub_right = 1'b0;
      sub_data = '0;
      sub_cs = 1'b0;
      sub_block_start = 1'b0;
   end
   // Holds one subframe until taken or 4000 tries pass; idle data is inverted so stale
   // values can never pass for fresh ones
   task automatic send(input logic r, input logic [SAMPLE_W-1:0] d,
                       input logic c, input logic bs, input int gap,
                       output logic ok);
      ok = 1'b0;
      repeat (gap + 1) @(negedge clock);
      sub_valid = 1'b1;
      sub_right = r;
      sub_data = d;
      sub_cs = c;
      sub_block_start = bs;
      for (int n = 0; n < 4000; n++) begin
         #1 ok = sub_ready;
         @(posedge clock);
         if (ok) break;
         @(negedge clock);
      end
      @(negedge clock);
      sub_valid = 1'b0;
      sub_data = ~d;
      sub_cs = ~c;
      sub_block_start = 1'b0;
   endtask
endmodule // sdlm_src

// *** verification/sdlm_top_tb.sv ***
// Self-checking bench for the lock, mute and sample control top
`timescale 1ns/1ps
module sdlm_top_tb;
   import sdlm_pkg::*;
   logic clock, arst_n, pin_control_select, serial_bus_select, mute_pin;
   logic soft_mute_wr, soft_mute_wr_data, lock_mute_bypass_bit;
   logic lock_pin_raw_sel, pll_locked, decoder_locked, burst_detect;
   logic [7:0] vol_left, vol_right;
   logic [3:0] bass_level, treble_level;
   logic [1:0] filter_mode;
   wire  sub_valid, sub_ready, sub_right, sub_cs, sub_block_start;
   wire  [SAMPLE_W-1:0] sub_data, left_sample, right_sample;
   wire  [CS_BITS-1:0]  cs_left, cs_right;
   wire  [1:0] ctrl_mode, rate_code;
   wire  lock_indicator_bit, lock_pin, pcm_detect_pin, soft_mute_bit;
   wire  muted_status, dac_left_bit, dac_right_bit;
   int   mismatches = 0;
   int   compares = 0;
   logic [1:0] mode_exp [3] = '{2'h0, 2'h1, 2'h3};

   // 100 MHz clock
   initial clock = 1'b0;
   always #5 clock = ~clock;

   sdlm_top u_sdlm_top (.clock(clock), .arst_n(arst_n),
      .pin_control_select(pin_control_select),
      .serial_bus_select(serial_bus_select), .mute_pin(mute_pin),
      .soft_mute_wr(soft_mute_wr), .soft_mute_wr_data(soft_mute_wr_data),
      .lock_mute_bypass_bit(lock_mute_bypass_bit),
      .lock_pin_raw_sel(lock_pin_raw_sel), .pll_locked(pll_locked),
      .decoder_locked(decoder_locked), .burst_detect(burst_detect),
      .sub_valid(sub_valid), .sub_ready(sub_ready), .sub_right(sub_right),
      .sub_data(sub_data), .sub_cs(sub_cs),
      .sub_block_start(sub_block_start), .vol_left(vol_left),
      .vol_right(vol_right), .bass_level(bass_level),
      .treble_level(treble_level), .filter_mode(filter_mode),
      .lock_indicator_bit(lock_indicator_bit), .lock_pin(lock_pin),
      .pcm_detect_pin(pcm_detect_pin), .ctrl_mode(ctrl_mode),
      .soft_mute_bit(soft_mute_bit), .muted_status(muted_status),
      .left_sample(left_sample), .right_sample(right_sample),
      .cs_left(cs_left), .cs_right(cs_right), .rate_code(rate_code),
      .dac_left_bit(dac_left_bit), .dac_right_bit(dac_right_bit));
   sdlm_src u_sdlm_src (.clock(clock), .sub_ready(sub_ready),
      .sub_valid(sub_valid), .sub_right(sub_right), .sub_data(sub_data),
      .sub_cs(sub_cs), .sub_block_start(sub_block_start));

   // ***************************************
   // Tasks
   // ***************************************
   task automatic stop_test();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic check(input logic [63:0] got, input logic [63:0] exp,
                        input string what);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: %s got %h", $time, what, got);
      end
   endtask
   // One subframe; a refusal that never ends closes the run
   task automatic sub(input logic r, input logic [23:0] d, input logic c,
                      input logic bs);
      logic ok;
      u_sdlm_src.send(r, d, c, bs, r ? 0 : 3, ok);
      if (!ok) begin
         mismatches++;
         stop_test();
      end
      check(r ? right_sample : left_sample, d, "sample");
   endtask
   // A whole block of 40 frames with its status bit patterns
   task automatic block(input logic [39:0] pl, input logic [39:0] pr);
      for (int i = 0; i < CS_BITS; i++) begin
         sub(1'b0, 24'h0a0000 + 24'(i), pl[i], i == 0);
         sub(1'b1, 24'hb00000 + 24'(i), pr[i], 1'b0);
      end
      check(cs_left, pl, "cs left");
      check(cs_right, pr, "cs right");
   endtask
   task automatic settle();
      repeat (2) @(negedge clock);
   endtask

   // ***************************************
   // Sequence
   // ***************************************
   initial begin
      {arst_n, pin_control_select, mute_pin, soft_mute_wr} = '0;
      {soft_mute_wr_data, lock_mute_bypass_bit, lock_pin_raw_sel} = '0;
      {pll_locked, decoder_locked, burst_detect} = '0;
      serial_bus_select = 1'b1;
      {vol_left, vol_right, bass_level, treble_level} = 24'h10_20_3_4;
      filter_mode = '0;
      repeat (20) @(negedge clock);
      arst_n = 1'b1;
      #1 check(soft_mute_bit, 1, "mute bit reset");
      @(negedge clock);
      check(muted_status, 1, "unlocked mute");
      // Every control mode in turn, tone mode moving along
      for (int m = 0; m < 3; m++) begin
         @(negedge clock);
         pin_control_select = (m == 2);
         serial_bus_select = (m == 1);
         filter_mode = 2'(m);
         #1 check(ctrl_mode, mode_exp[m], "mode");
      end
      @(negedge clock);
      pin_control_select = 1'b0;
      {pll_locked, decoder_locked} = 2'b11;
      #1 check(lock_indicator_bit, 1, "lock bit");
      @(negedge clock);
      check(muted_status, 1, "start-up mute");
      // Clear soft mute while the pin still mutes
      soft_mute_wr = 1'b1;
      mute_pin = 1'b1;
      @(negedge clock);
      soft_mute_wr = 1'b0;
      check(soft_mute_bit, 0, "mute bit cleared");
      pin_control_select = 1'b1;
      soft_mute_wr = 1'b1;
      soft_mute_wr_data = 1'b1;
      @(negedge clock);
      soft_mute_wr = 1'b0;
      check(soft_mute_bit, 0, "static write");
      pin_control_select = 1'b0;
      block(40'h5a_3c96_0f0c, 40'ha5_c369_f0f0);
      check(sub_ready, 0, "sample buffer full");
      settle();
      check(lock_pin, 1, "lock pcm");
      check(pcm_detect_pin, 1, "pcm");
      check(muted_status, 1, "pin mute");
      // Release the pin: the ramp leaves the muted state on the next frame tick
      mute_pin = 1'b0;
      repeat (200) @(negedge clock);
      check(muted_status, 0, "ramp rise");
      mute_pin = 1'b1;
      settle();
      check(muted_status, 0, "no abrupt cut");
      repeat (600) @(negedge clock);
      check(muted_status, 1, "ramp fall");
      check(sub_ready, 1, "sample buffer drained");
      burst_detect = 1'b1;
      settle();
      check(pcm_detect_pin, 0, "burst");
      burst_detect = 1'b0;
      block(40'h00_0000_0002, 40'hff_ffff_fffd);
      settle();
      check(lock_pin, 0, "lock non-pcm");
      check(pcm_detect_pin, 0, "non-pcm");
      lock_pin_raw_sel = 1'b1;
      settle();
      check(lock_pin, 1, "raw lock");
      pin_control_select = 1'b1;
      settle();
      check(lock_pin, 0, "static raw");
      {pin_control_select, lock_pin_raw_sel, pll_locked, mute_pin} = '0;
      lock_mute_bypass_bit = 1'b1;
      #1 check(lock_indicator_bit, 0, "unlock bit");
      settle();
      check(lock_pin, 0, "lock pin unlock");
      // Bypass lets the ramp rise although unlocked
      repeat (1600) @(negedge clock);
      check(muted_status, 0, "bypass unmuted");
      {lock_mute_bypass_bit, decoder_locked} = '0;
      #1 check(muted_status, 1, "hard mute");
      // Second reset in mid-run
      arst_n = 1'b0;
      settle();
      arst_n = 1'b1;
      #1 check(soft_mute_bit, 1, "mute bit reset");
      stop_test();
   end
endmodule // sdlm_top_tb

bind sdlm_top sdlm_chk u_sdlm_chk (.clock(clock), .arst_n(arst_n),
   .pin_control_select(pin_control_select),
   .serial_bus_select(serial_bus_select), .soft_mute_wr(soft_mute_wr),
   .soft_mute_wr_data(soft_mute_wr_data),
   .lock_mute_bypass_bit(lock_mute_bypass_bit),
   .lock_pin_raw_sel(lock_pin_raw_sel), .pll_locked(pll_locked),
   .decoder_locked(decoder_locked), .burst_detect(burst_detect),
   .sub_valid(sub_valid), .sub_ready(sub_ready), .sub_right(sub_right),
   .sub_data(sub_data), .cs_left(cs_left),
   .lock_indicator_bit(lock_indicator_bit), .lock_pin(lock_pin),
   .pcm_detect_pin(pcm_detect_pin), .ctrl_mode(ctrl_mode),
   .soft_mute_bit(soft_mute_bit), .muted_status(muted_status),
   .left_sample(left_sample), .right_sample(right_sample));
